// ==== core/pwc_top.sv ====
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module pwc_top (
    // System
    input wire logic CLK_SYS,
    input wire logic RST,
    // Source clocks, asynchronous to CLK_SYS
    input wire logic LOW_POWER_OSC_1K,
    input wire logic EXTERNAL_REF_CLOCK,
    input wire logic INTERNAL_REF_CLOCK,
    // Background debug freeze level
    input wire logic DEBUG_HALT,
    // Register port
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Interrupt request
    output logic MATCH_IRQ
);
    typedef struct packed {
        logic match_flag;
        logic [1:0] source_select;
        logic match_irq_enable;
        logic [3:0] divider_select;
        logic [7:0] count_value;
        logic [7:0] match_limit;
        logic [pwc_pkg::PRE_W-1:0] pre_cnt;
        logic src_prev;
        logic [7:0] rdata;
    } pwc_state_t;

    pwc_state_t st_ff;
    pwc_state_t nxt_st;

    logic osc1k_s;
    logic ext_s;
    logic irc_s;
    logic halt_s;
    logic src_lvl;
    logic src_rise;
    logic pre_tick;
    logic clr_cnt;
    logic set_flag;
    logic [pwc_pkg::PRE_W-1:0] pre_last;
    logic [7:0] csr_val;
    logic [1:0] w_src;
    logic [3:0] w_div;

    // Each source is a slow clock; it is sampled as a level and its
    // rising edge detected after the second stage
    pwc_sync u_sync_osc1k (
        .clk(CLK_SYS),
        .rst(RST),
        .din(LOW_POWER_OSC_1K),
        .dout(osc1k_s)
    );
    pwc_sync u_sync_ext (
        .clk(CLK_SYS),
        .rst(RST),
        .din(EXTERNAL_REF_CLOCK),
        .dout(ext_s)
    );
    pwc_sync u_sync_irc (
        .clk(CLK_SYS),
        .rst(RST),
        .din(INTERNAL_REF_CLOCK),
        .dout(irc_s)
    );
    pwc_sync u_sync_halt (
        .clk(CLK_SYS),
        .rst(RST),
        .din(DEBUG_HALT),
        .dout(halt_s)
    );

    pwc_ratio u_ratio (
        .src_lsb(st_ff.source_select[0]),
        .div_sel(st_ff.divider_select),
        .last(pre_last)
    );

    always_comb begin
        // Upper bit set means internal reference either way
        if (st_ff.source_select[1]) begin
            src_lvl = irc_s;
        end else if (st_ff.source_select == pwc_pkg::SRC_EXT) begin
            src_lvl = ext_s;
        end else begin
            src_lvl = osc1k_s;
        end
    end

    // Sources above half of CLK_SYS cannot be followed; fine for 1 MHz
    assign src_rise = src_lvl && !st_ff.src_prev;
    // Divider select zero keeps the prescaler off
    assign pre_tick = src_rise && (st_ff.divider_select != 4'h0)
        && !halt_s && (st_ff.pre_cnt == pre_last);
    // Only a tick that matches sets the flag; a plain tick must not
    // block a clear arriving in the same cycle
    assign set_flag = pre_tick && (st_ff.count_value == st_ff.match_limit);

    assign w_src = WDATA[pwc_pkg::SRC_SEL_HI:pwc_pkg::SRC_SEL_LO];
    assign w_div = WDATA[pwc_pkg::DIV_SEL_HI:pwc_pkg::DIV_SEL_LO];

    always_comb begin
        csr_val = 8'h00;
        csr_val[pwc_pkg::MATCH_FLAG_BIT] = st_ff.match_flag;
        csr_val[pwc_pkg::SRC_SEL_HI:pwc_pkg::SRC_SEL_LO] =
            st_ff.source_select;
        csr_val[pwc_pkg::IRQ_EN_BIT] = st_ff.match_irq_enable;
        csr_val[pwc_pkg::DIV_SEL_HI:pwc_pkg::DIV_SEL_LO] =
            st_ff.divider_select;
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.src_prev = src_lvl;
        clr_cnt = 1'b0;

        // Prescaler runs only while selected, enabled and not frozen
        if (src_rise && st_ff.divider_select != 4'h0 && !halt_s) begin
            if (pre_tick) begin
                nxt_st.pre_cnt = '0;
            end else begin
                nxt_st.pre_cnt = st_ff.pre_cnt + 1'b1;
            end
        end

        if (pre_tick) begin
            // Limit zero lands here each tick, count stays 0
            if (st_ff.count_value == st_ff.match_limit) begin
                nxt_st.count_value = pwc_pkg::COUNT_RST;
                nxt_st.match_flag = 1'b1;
            end else begin
                nxt_st.count_value = st_ff.count_value + 8'h01;
            end
        end

        // Write-one-clear loses to a coinciding set
        if (WR && ADDR == pwc_pkg::OFF_CONTROL_STATUS) begin
            if (WDATA[pwc_pkg::MATCH_FLAG_BIT] && !set_flag) begin
                nxt_st.match_flag = 1'b0;
            end
            nxt_st.match_irq_enable = WDATA[pwc_pkg::IRQ_EN_BIT];
            nxt_st.source_select = w_src;
            nxt_st.divider_select = w_div;
            if (w_src != st_ff.source_select) begin
                clr_cnt = 1'b1;
            end
            if (w_div != st_ff.divider_select) begin
                clr_cnt = 1'b1;
            end
        end
        if (WR && ADDR == pwc_pkg::OFF_MATCH_LIMIT) begin
            nxt_st.match_limit = WDATA;
            clr_cnt = 1'b1;
        end
        // Writes to the count offset fall through untouched
        if (clr_cnt) begin
            nxt_st.pre_cnt = '0;
            nxt_st.count_value = pwc_pkg::COUNT_RST;
        end

        nxt_st.rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                pwc_pkg::OFF_CONTROL_STATUS: nxt_st.rdata = csr_val;
                pwc_pkg::OFF_COUNT_VALUE: begin
                    nxt_st.rdata = st_ff.count_value;
                end
                pwc_pkg::OFF_MATCH_LIMIT: nxt_st.rdata = st_ff.match_limit;
                default: nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st_ff.match_flag <= 1'b0;
            st_ff.source_select <= pwc_pkg::SRC_SEL_RST;
            st_ff.match_irq_enable <= 1'b0;
            st_ff.divider_select <= pwc_pkg::DIV_SEL_RST;
            st_ff.count_value <= pwc_pkg::COUNT_RST;
            st_ff.match_limit <= pwc_pkg::LIMIT_RST;
            st_ff.pre_cnt <= '0;
            st_ff.src_prev <= 1'b0;
            st_ff.rdata <= 8'h00;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign RDATA = st_ff.rdata;
    assign MATCH_IRQ = st_ff.match_flag && st_ff.match_irq_enable;
endmodule : pwc_top
`default_nettype wire

// ==== core/pwc_pkg.sv ====
`default_nettype none
package pwc_pkg;
    // Register offsets on the plain register port
    localparam logic [1:0] OFF_CONTROL_STATUS = 2'h0;
    localparam logic [1:0] OFF_COUNT_VALUE = 2'h1;
    localparam logic [1:0] OFF_MATCH_LIMIT = 2'h2;
    // Field positions in control_status
    localparam int MATCH_FLAG_BIT = 7;
    localparam int SRC_SEL_HI = 6;
    localparam int SRC_SEL_LO = 5;
    localparam int IRQ_EN_BIT = 4;
    localparam int DIV_SEL_HI = 3;
    localparam int DIV_SEL_LO = 0;
    // Reset values
    localparam logic [1:0] SRC_SEL_RST = 2'h0;
    localparam logic [3:0] DIV_SEL_RST = 4'h0;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] LIMIT_RST = 8'h00;
    // Source select codes
    localparam logic [1:0] SRC_LOW_POWER = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;
    // Prescaler counter width covers the largest ratio, 200000
    localparam int PRE_W = 18;
endpackage : pwc_pkg
`default_nettype wire

// ==== core/pwc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwc_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Asynchronous level in, synchronous level out
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic meta;
        logic sync;
    } pwc_sync_t;
    pwc_sync_t st_ff;
    pwc_sync_t nxt_st;

    always_comb begin
        nxt_st.meta = din;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.sync;
endmodule : pwc_sync
`default_nettype wire

// ==== core/pwc_ratio.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwc_ratio (
    // Selection
    input wire logic src_lsb,
    input wire logic [3:0] div_sel,
    // Terminal value of the prescaler count, ratio minus one
    output logic [pwc_pkg::PRE_W-1:0] last
);
    logic [17:0] ratio;

    always_comb begin
        ratio = 18'h00001;
        if (!src_lsb) begin
            case (div_sel)
                4'h1: ratio = 18'h00008;
                4'h2: ratio = 18'h00020;
                4'h3: ratio = 18'h00040;
                4'h4: ratio = 18'h00080;
                4'h5: ratio = 18'h00100;
                4'h6: ratio = 18'h00200;
                4'h7: ratio = 18'h00400;
                4'h8: ratio = 18'h00001;
                4'h9: ratio = 18'h00002;
                4'ha: ratio = 18'h00004;
                4'hb: ratio = 18'h0000a;
                4'hc: ratio = 18'h00010;
                4'hd: ratio = 18'h00064;
                4'he: ratio = 18'h001f4;
                4'hf: ratio = 18'h003e8;
                default: ratio = 18'h00001;
            endcase
        end else begin
            case (div_sel)
                4'h1: ratio = 18'h00400;
                4'h2: ratio = 18'h00800;
                4'h3: ratio = 18'h01000;
                4'h4: ratio = 18'h02000;
                4'h5: ratio = 18'h04000;
                4'h6: ratio = 18'h08000;
                4'h7: ratio = 18'h10000;
                4'h8: ratio = 18'h003e8;
                4'h9: ratio = 18'h007d0;
                4'ha: ratio = 18'h01388;
                4'hb: ratio = 18'h02710;
                4'hc: ratio = 18'h04e20;
                4'hd: ratio = 18'h0c350;
                4'he: ratio = 18'h186a0;
                4'hf: ratio = 18'h30d40;
                default: ratio = 18'h00001;
            endcase
        end
        last = ratio - 18'h00001;
    end
endmodule : pwc_ratio
`default_nettype wire

// ==== dv/pwc_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwc_top_sva (
    // Watched ports
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic DEBUG_HALT,
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic MATCH_IRQ
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic idle;
    assign idle = !WR && !RD;
    // Freeze cases wait 4 cycles so the synchronised halt has landed
    chk_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data not zero outside a read");
    chk_unmapped_zero: assert property (RD && ADDR == 2'h3 |=>
        RDATA == 8'h00)
        else $error("unmapped read not zero");
    chk_limit_rw: assert property (WR && ADDR == 2'h2 ##1 idle ##1
        RD && ADDR == 2'h2 |=> RDATA == $past(WDATA, 3))
        else $error("limit readback wrong");
    chk_ctrl_rw: assert property (WR && ADDR == 2'h0
        ##1 idle ##1 RD && ADDR == 2'h0
        |=> RDATA[6:0] == 7'($past(WDATA, 3)))
        else $error("control readback wrong");
    chk_irq_level: assert property (RD && ADDR == 2'h0 |=>
        (RDATA[7] && RDATA[4]) == $past(MATCH_IRQ))
        else $error("irq differs from flag and enable");
    chk_flag_w1c: assert property (DEBUG_HALT [*4] ##0
        (WR && ADDR == 2'h0 && WDATA[7]) ##1 idle ##1
        (RD && ADDR == 2'h0) |=> !RDATA[7])
        else $error("flag not cleared by one");
    chk_halt_hold: assert property (DEBUG_HALT [*4] ##0
        (RD && ADDR == 2'h1) ##1 idle ##1 (WR && ADDR == 2'h1 && DEBUG_HALT)
        ##1 idle ##1 (RD && ADDR == 2'h1 && DEBUG_HALT)
        |=> RDATA == $past(RDATA, 4))
        else $error("count moved while frozen");
    chk_limit_clr: assert property (DEBUG_HALT [*4] ##0
        (WR && ADDR == 2'h2) ##1 idle ##1 (RD && ADDR == 2'h1 && DEBUG_HALT)
        |=> RDATA == 8'h00)
        else $error("limit write left count");
endmodule : pwc_top_sva
bind pwc_top pwc_top_sva pwc_top_sva_inst (.CLK_SYS(CLK_SYS), .RST(RST),
    .DEBUG_HALT(DEBUG_HALT), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .MATCH_IRQ(MATCH_IRQ));
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic src = 1'b0;
    // Gates: bit 0 low-power, bit 1 external, bit 2 internal source
    logic [2:0] src_en = 3'h1;
    logic DEBUG_HALT = 1'b0;
    logic [1:0] ADDR = 2'h0;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] RDATA;
    logic MATCH_IRQ;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    always #5 CLK_SYS = ~CLK_SYS;
    // One edge generator, gated per source so a wrong pick shows up
    pwc_top pwc_top_inst (.CLK_SYS(CLK_SYS), .RST(RST),
        .LOW_POWER_OSC_1K(src && src_en[0]),
        .EXTERNAL_REF_CLOCK(src && src_en[1]),
        .INTERNAL_REF_CLOCK(src && src_en[2]), .DEBUG_HALT(DEBUG_HALT),
        .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .MATCH_IRQ(MATCH_IRQ));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge CLK_SYS);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK_SYS);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] exp,
                      input string what);
        @(posedge CLK_SYS);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        @(negedge CLK_SYS);
        chk(RDATA, exp, what);
    endtask : rd
    task automatic irq(input logic exp);
        @(negedge CLK_SYS);
        chk({7'h00, MATCH_IRQ}, {7'h00, exp}, "irq");
    endtask : irq
    // Slow source edges leave room for the two-flop synchroniser
    task automatic edges(input int n);
        repeat (n) begin
            repeat (4) @(posedge CLK_SYS);
            src <= 1'b1;
            repeat (4) @(posedge CLK_SYS);
            src <= 1'b0;
        end
        repeat (6) @(posedge CLK_SYS);
    endtask : edges
    task automatic stop_test;
        $display("counts: %0d mismatches %0d comparisons", mismatches,
                 comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic t_reset;
        rd(2'h0, 8'h00, "ctrl");
        rd(2'h1, 8'h00, "count");
        rd(2'h2, 8'h00, "limit");
        rd(2'h3, 8'h00, "unmapped");
        edges(2);
        rd(2'h1, 8'h00, "count off");
        $display("test reset done");
    endtask : t_reset
    task automatic t_match;
        wr(2'h2, 8'h03);
        wr(2'h0, 8'h18);
        edges(3);
        rd(2'h1, 8'h03, "count");
        rd(2'h0, 8'h18, "no flag at limit");
        edges(1);
        rd(2'h1, 8'h00, "wrap");
        rd(2'h0, 8'h98, "flag");
        irq(1'b1);
        wr(2'h0, 8'h08);
        irq(1'b0);
        rd(2'h0, 8'h88, "write zero");
        wr(2'h0, 8'h88);
        rd(2'h0, 8'h08, "write one");
        $display("test match done");
    endtask : t_match
    task automatic t_div;
        wr(2'h0, 8'h09);
        edges(3);
        rd(2'h1, 8'h01, "ratio two");
        wr(2'h0, 8'h29);
        src_en <= 3'h2;
        rd(2'h1, 8'h00, "source change");
        edges(3);
        rd(2'h1, 8'h00, "ratio 2000");
        wr(2'h0, 8'h28);
        edges(999);
        rd(2'h1, 8'h00, "ratio 1000 early");
        edges(1);
        rd(2'h1, 8'h01, "ratio 1000");
        wr(2'h0, 8'h48);
        src_en <= 3'h3;
        edges(2);
        rd(2'h1, 8'h00, "internal unselected");
        @(posedge CLK_SYS);
        src_en <= 3'h4;
        edges(2);
        rd(2'h1, 8'h02, "internal ref");
        $display("test divider done");
    endtask : t_div
    task automatic t_lim0;
        wr(2'h2, 8'h00);
        rd(2'h1, 8'h00, "limit write");
        edges(1);
        rd(2'h0, 8'hc8, "flag one");
        wr(2'h0, 8'hc8);
        rd(2'h0, 8'h48, "cleared");
        edges(1);
        rd(2'h0, 8'hc8, "flag two");
        $display("test limit zero done");
    endtask : t_lim0
    task automatic t_halt;
        wr(2'h2, 8'h09);
        edges(2);
        DEBUG_HALT <= 1'b1;
        edges(2);
        rd(2'h1, 8'h02, "frozen");
        wr(2'h1, 8'h55);
        rd(2'h1, 8'h02, "count write");
        wr(2'h2, 8'h09);
        rd(2'h1, 8'h00, "limit clears");
        wr(2'h0, 8'hc8);
        rd(2'h0, 8'h48, "flag clear");
        DEBUG_HALT <= 1'b0;
        edges(1);
        rd(2'h1, 8'h01, "resumed");
        $display("test halt done");
    endtask : t_halt
    // Puts a control write on the very edge that takes a source tick
    task automatic tick_wr(input logic [7:0] d);
        @(posedge CLK_SYS);
        src <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        WR <= 1'b1;
        ADDR <= 2'h0;
        WDATA <= d;
        @(posedge CLK_SYS);
        WR <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        src <= 1'b0;
        repeat (4) @(posedge CLK_SYS);
    endtask : tick_wr
    task automatic t_race;
        wr(2'h2, 8'h01);
        rd(2'h2, 8'h01, "limit");
        edges(2);
        rd(2'h0, 8'hc8, "flag set");
        tick_wr(8'hc8);
        rd(2'h0, 8'h48, "clear beside tick");
        rd(2'h1, 8'h01, "count beside clear");
        tick_wr(8'hc8);
        rd(2'h0, 8'hc8, "set beats clear");
        $display("test race done");
    endtask : t_race
    always @(posedge CLK_SYS) begin
        cycles <= cycles + 1;
        // The ratio 1000 run alone takes about 8000 cycles
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        repeat (2) @(posedge CLK_SYS);
        RST <= 1'b0;
        t_reset();
        t_match();
        t_div();
        t_lim0();
        t_halt();
        t_race();
        stop_test();
    end
endmodule : testbench
`default_nettype wire
